// ==== sim/servo_position_velocity_cmd_bench.sv ====
// Self-checking bench for the servo command core
module servo_position_velocity_cmd_bench;
    import spv_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TK = 10;
    logic clk, rstn, wr, rd, go, down, pos, clr, pulse_inhibit_in, sgn, pul, pdir, busy;
    logic [7:0]  addr, cnt;
    logic [31:0] wdata, rdata, dev, spd;
    logic [15:0] ain;
    logic [2:0]  sel;
    logic irq, out1, out2, inh_act;
    int n_mismatch, n_compared, cyc;
    spv_cmd_core #(.CTRL_CYC(TK)) dut (.REF_CLK(clk), .RSTN(rstn), .ADDR(addr), .WDATA(wdata),
        .WR(wr), .RD(rd), .RDATA(rdata), .IRQ(irq), .POS_MODE(pos), .CMD_PULSE(pul), .CMD_DIR(pdir),
        .FB_PULSE(1'b0), .FB_DIR(1'b0), .DEVIATION_CLEAR_IN(clr), .PULSE_INHIBIT_IN(pulse_inhibit_in),
        .IN_POSITION_OUT_FIRST(out1), .IN_POSITION_OUT_SECOND(out2), .INHIBIT_ACTIVE(inh_act),
        .DEVIATION_COUNT(dev), .ANALOG_INPUT_FIRST(ain), .PRESET_SPEED_SEL(sel),
        .SPEED_SIGN_IN(sgn), .SPEED_CMD(spd));
    spv_host_model host (.clk(clk), .rst_n(rstn), .go(go), .count(cnt), .down(down),
        .cmd_pulse(pul), .cmd_dir(pdir), .busy(busy));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ==========================================
    // Access and check tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        // Sampled at the next edge, before the read data drops
        @(posedge clk);
        chk(rdata, exp);
    endtask
    task automatic burst(input logic [7:0] n, input logic dn);
        @(posedge clk);
        cnt <= n;
        down <= dn;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        repeat (300) if (busy === 1'b1 || go === 1'b1) @(posedge clk);
        repeat (2) @(posedge clk);
    endtask
    task automatic pulse_clr();
        @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    task automatic ticks(input int n);
        repeat (n * TK) @(posedge clk);
    endtask
    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Hang guard, far above the roughly 1800 cycles the sequence needs
    always @(posedge clk) begin
        cyc++;
        if (cyc == 8000) begin
            n_mismatch++;
            wrap_up();
        end
    end
    // ==========================================
    // Main sequence
    initial begin
        {rstn, wr, rd, go, down, pos, clr, pulse_inhibit_in, sgn} = '0;
        {addr, cnt, wdata, ain, sel} = '0;
        n_mismatch = 0;
        n_compared = 0;
        cyc = 0;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        rchk(REG_CTRL, 32'h0000_0000);
        rchk(REG_RANGE1, 32'h0000_000a);
        rchk(REG_GAIN, 32'h0000_01f4);
        rchk(8'h3c, 32'h0000_0000);
        pos <= 1'b1;
        burst(8'h05, 1'b0);
        chk(dev, 32'h0000_0005);
        wreg(REG_MASK, 32'h0000_0001);
        pulse_clr();
        chk(dev, 32'h0000_0000);
        chk({31'h0, irq}, 32'h0000_0001);
        wreg(REG_STATUS, 32'h0000_0001);
        @(posedge clk);
        chk({31'h0, irq}, 32'h0000_0000);
        pos <= 1'b0;
        burst(8'h02, 1'b0);
        pulse_clr();
        chk(dev, 32'h0000_0002);
        pos <= 1'b1;
        wreg(REG_CTRL, {29'h0, CLR_OFF});
        pulse_clr();
        chk(dev, 32'h0000_0002);
        wreg(REG_CTRL, {29'h0, CLR_RISE});
        pulse_clr();
        chk(dev, 32'h0000_0000);
        burst(8'h03, 1'b0);
        wreg(REG_RANGE1, 32'h0000_0002);
        wreg(REG_RANGE2, 32'h0000_0005);
        ticks(2);
        chk({30'h0, out2, out1}, 32'h0000_0002);
        wreg(REG_RANGE1, 32'h0000_0003);
        ticks(2);
        chk({31'h0, out1}, 32'h0000_0001);
        wreg(REG_CTRL, 32'h0000_0021);
        pulse_inhibit_in <= 1'b1;
        ticks(3);
        chk({31'h0, inh_act}, 32'h0000_0001);
        burst(8'h04, 1'b0);
        chk(dev, 32'h0000_0003);
        wreg(REG_CTRL, 32'h0000_00a1);
        pulse_inhibit_in <= 1'b0;
        ticks(2);
        chk({31'h0, inh_act}, 32'h0000_0001);
        ticks(5);
        chk({31'h0, inh_act}, 32'h0000_0000);
        burst(8'h01, 1'b1);
        chk(dev, 32'h0000_0002);
        // Range plus no command: output is on again two ticks after the trains end
        wreg(REG_CTRL, 32'h0000_0009);
        burst(8'h20, 1'b1);
        burst(8'h20, 1'b0);
        ticks(2);
        chk({31'h0, out1}, 32'h0000_0001);
        // Hold of 1 ms keeps the output on after the deviation leaves range
        wreg(REG_HOLD, 32'h0000_0001);
        wreg(REG_CTRL, 32'h0000_0019);
        ticks(1);
        burst(8'h05, 1'b0);
        ticks(2);
        chk({31'h0, out1}, 32'h0000_0001);
        ticks(MS_TICKS);
        chk({31'h0, out1}, 32'h0000_0000);
        for (int k = 0; k < 8; k++) wreg(REG_PRESET0 + 8'(4 * k), 32'(k * 5000 - 15000));
        wreg(REG_CTRL, {19'h0, 1'b0, 1'b0, SRC_PRESET8, 6'h0, CLR_RISE});
        for (int k = 0; k < 8; k++) begin
            sel <= 3'(k);
            ticks(3);
            chk(spd, 32'(k * 5000 - 15000));
        end
        sgn <= 1'b1;
        sel <= 3'h6;
        wreg(REG_CTRL, {19'h0, 1'b0, 1'b1, SRC_PRESET8, 6'h0, CLR_RISE});
        ticks(3);
        chk(spd, 32'(-15000));
        ain <= 16'd10000;
        wreg(REG_GAIN, 32'd1000);
        wreg(REG_CTRL, {19'h0, 1'b0, 1'b0, SRC_ANALOG, 6'h0, CLR_RISE});
        ticks(4);
        chk(spd, 32'((longint'(10000) * 1000 * ADC_LSB_UV) / UV_PER_V));
        wreg(REG_CTRL, {19'h0, 1'b1, 1'b0, SRC_ANALOG, 6'h0, CLR_RISE});
        ticks(4);
        chk(spd, 32'(-(longint'(10000) * 1000 * ADC_LSB_UV) / UV_PER_V));
        wreg(REG_CTRL, {29'h0, CLR_RISE});
        wreg(REG_OFFSET, 32'd100);
        ticks(4);
        chk(spd, 32'((longint'(10100) * 1000 * ADC_LSB_UV) / UV_PER_V));
        wrap_up();
    end
endmodule

// ==== sim/spv_host_model.sv ====
// Host controller model that issues bursts of command pulses
module spv_host_model (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Burst request
    input  wire logic       go,
    input  wire logic [7:0] count,
    input  wire logic       down,
    // Pulse outputs
    output logic            cmd_pulse,
    output logic            cmd_dir,
    output logic            busy
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] left_q;
    // One pulse a cycle, the densest train the core must count
    assign busy      = (left_q != 8'h00);
    assign cmd_pulse = busy;
    // ==========================================
    // Burst counter
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            left_q  <= 8'h00;
            cmd_dir <= 1'b0;
        end else if (go) begin
            left_q  <= count;
            cmd_dir <= down;
        end else if (busy) begin
            left_q <= left_q - 8'h01;
        end
    end
endmodule

// ==== src/spv_cmd_core.sv ====
// Servo command core: deviation clear, in-position, pulse inhibit, speed command
//
// The register offsets and the plain strobed port were chosen for this implementation.
module spv_cmd_core
    import spv_pkg::*;
#(
    parameter int CTRL_CYC = CTRL_CYC_DEF
)(
    // Clock and reset
    input  wire logic        REF_CLK,
    input  wire logic        RSTN,
    // Register port
    input  wire logic [7:0]  ADDR,
    input  wire logic [31:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [31:0] RDATA,
    output logic             IRQ,
    // Position path
    input  wire logic        POS_MODE,
    input  wire logic        CMD_PULSE,
    input  wire logic        CMD_DIR,
    input  wire logic        FB_PULSE,
    input  wire logic        FB_DIR,
    input  wire logic        DEVIATION_CLEAR_IN,
    input  wire logic        PULSE_INHIBIT_IN,
    output logic             IN_POSITION_OUT_FIRST,
    output logic             IN_POSITION_OUT_SECOND,
    output logic             INHIBIT_ACTIVE,
    output logic      [31:0] DEVIATION_COUNT,
    // Velocity path
    input  wire logic [15:0] ANALOG_INPUT_FIRST,
    input  wire logic [2:0]  PRESET_SPEED_SEL,
    input  wire logic        SPEED_SIGN_IN,
    output logic      [31:0] SPEED_CMD
);

    localparam logic [15:0] TICK_LAST = 16'(CTRL_CYC - 1);

    function automatic logic [31:0] mag32(input logic signed [31:0] v);
        mag32 = v[31] ? 32'(-v) : 32'(v);
    endfunction

    // ==========================================
    // Registers
    spv_cfg_t                cfg_q;
    logic        [18:0]      range1_q;
    logic        [18:0]      range2_q;
    logic        [14:0]      hold_q;
    logic        [10:0]      gain_q;
    logic signed [13:0]      offset_q;
    logic        [12:0]      filt_q;
    logic        [ST_W-1:0]  status_q;
    logic        [ST_W-1:0]  mask_q;
    logic signed [15:0]      preset_q [8];
    logic        [31:0]      rdata_q;
    logic        [15:0]      tick_cnt_q;
    logic signed [31:0]      dev_q;
    logic                    clr_prev_q;
    logic                    cmd_seen_q;
    logic                    out1_q;
    logic                    out2_q;
    logic        [21:0]      hold_cnt_q;
    logic                    smp_last_q;
    logic        [3:0]       agree_q;
    logic                    inhibit_state_q;
    logic signed [25:0]      filt_y_q;
    logic signed [31:0]      spd_q;

    // ==========================================
    // Register port decode
    wire logic        tick        = (tick_cnt_q == TICK_LAST);
    wire logic        wr_ctrl     = WR && (ADDR == REG_CTRL);
    wire logic        wr_range1   = WR && (ADDR == REG_RANGE1);
    wire logic        wr_range2   = WR && (ADDR == REG_RANGE2);
    wire logic        wr_hold     = WR && (ADDR == REG_HOLD);
    wire logic        wr_gain     = WR && (ADDR == REG_GAIN);
    wire logic        wr_offset   = WR && (ADDR == REG_OFFSET);
    wire logic        wr_filter   = WR && (ADDR == REG_FILTER);
    wire logic        wr_status   = WR && (ADDR == REG_STATUS);
    wire logic        wr_mask     = WR && (ADDR == REG_MASK);
    wire logic        preset_hit  = (ADDR[7:5] == REG_PRESET0[7:5]) && (ADDR[1:0] == 2'h0);
    wire logic        wr_preset   = WR && preset_hit;
    wire logic [2:0]  preset_idx  = ADDR[4:2];

    logic [31:0] rd_val;
    always_comb begin
        if (ADDR == REG_CTRL)
            rd_val = cfg_q;
        else if (ADDR == REG_RANGE1)
            rd_val = {13'h0, range1_q};
        else if (ADDR == REG_RANGE2)
            rd_val = {13'h0, range2_q};
        else if (ADDR == REG_HOLD)
            rd_val = {17'h0, hold_q};
        else if (ADDR == REG_GAIN)
            rd_val = {21'h0, gain_q};
        else if (ADDR == REG_OFFSET)
            rd_val = 32'(offset_q);
        else if (ADDR == REG_FILTER)
            rd_val = {19'h0, filt_q};
        else if (ADDR == REG_STATUS)
            rd_val = {28'h0, status_q};
        else if (ADDR == REG_MASK)
            rd_val = {28'h0, mask_q};
        else if (ADDR == REG_DEV)
            rd_val = dev_q;
        else if (ADDR == REG_SPEED)
            rd_val = spd_q;
        else if (ADDR == REG_LIVE)
            rd_val = {28'h0, inhibit_state_q, out2_q, out1_q, POS_MODE};
        else if (preset_hit)
            rd_val = 32'(preset_q[preset_idx]);
        else
            rd_val = 32'h0;
    end

    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            cfg_q    <= '0;
            range1_q <= RANGE1_RST;
            range2_q <= RANGE2_RST;
            hold_q   <= HOLD_RST;
            gain_q   <= GAIN_RST;
            offset_q <= OFFSET_RST;
            filt_q   <= FILTER_RST;
            mask_q   <= '0;
            rdata_q  <= '0;
            for (int i = 0; i < 8; i++) begin
                preset_q[i] <= '0;
            end
        end else begin
            if (wr_ctrl)
                cfg_q <= spv_cfg_t'({19'h0, WDATA[12:0]});
            if (wr_range1)
                range1_q <= WDATA[18:0];
            if (wr_range2)
                range2_q <= WDATA[18:0];
            if (wr_hold)
                hold_q <= WDATA[14:0];
            if (wr_gain)
                gain_q <= WDATA[10:0];
            if (wr_offset)
                offset_q <= WDATA[13:0];
            if (wr_filter)
                filt_q <= WDATA[12:0];
            if (wr_mask)
                mask_q <= WDATA[ST_W-1:0];
            if (wr_preset)
                preset_q[preset_idx] <= WDATA[15:0];
            // Read data stands only in the cycle after the strobe
            rdata_q <= RD ? rd_val : 32'h0;
        end
    end

    // ==========================================
    // Control cycle timer
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN)
            tick_cnt_q <= '0;
        else
            tick_cnt_q <= tick ? 16'h0 : tick_cnt_q + 16'h1;
    end

    // ==========================================
    // Deviation counter with clear and inhibit
    wire logic inhibit_act = cfg_q.inhibit_en && inhibit_state_q;
    wire logic cmd_ok      = CMD_PULSE && !inhibit_act;
    wire logic clr_rise    = DEVIATION_CLEAR_IN && !clr_prev_q;
    wire logic clr_fall    = !DEVIATION_CLEAR_IN && clr_prev_q;
    wire logic clr_sel     = (cfg_q.clear_mode == CLR_LEVEL) ? DEVIATION_CLEAR_IN :
                             (cfg_q.clear_mode == CLR_RISE)  ? clr_rise :
                             (cfg_q.clear_mode == CLR_FALL)  ? clr_fall :
                             (cfg_q.clear_mode == CLR_BOTH)  ? (clr_rise || clr_fall) : 1'b0;
    wire logic clr_hit     = POS_MODE && clr_sel;

    wire logic signed [31:0] cmd_step = !cmd_ok ? 32'sh0 : (CMD_DIR ? -32'sh1 : 32'sh1);
    wire logic signed [31:0] fb_step  = !FB_PULSE ? 32'sh0 : (FB_DIR ? -32'sh1 : 32'sh1);
    wire logic signed [31:0] dev_d    = clr_hit ? 32'sh0 : dev_q + cmd_step - fb_step;

    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            dev_q      <= '0;
            clr_prev_q <= 1'b0;
        end else begin
            dev_q      <= dev_d;
            clr_prev_q <= DEVIATION_CLEAR_IN;
        end
    end

    // ==========================================
    // In-position outputs
    // Tested on dev_d so a clear in the tick cycle is already seen
    wire logic [31:0] dev_mag   = mag32(dev_d);
    wire logic        near1     = dev_mag <= {13'h0, range1_q};
    wire logic        near2     = dev_mag <= {13'h0, range2_q};
    wire logic        no_cmd    = !(cmd_seen_q || cmd_ok);
    wire logic        need_nc   = cfg_q.in_pos_cond[0] ^ cfg_q.in_pos_cond[1];
    wire logic        use_hold  = cfg_q.in_pos_cond[1];
    wire logic        base1     = near1 && (!need_nc || no_cmd);
    wire logic [21:0] hold_load = 22'(32'(hold_q) * MS_TICKS);
    wire logic        holding   = use_hold && (hold_cnt_q != 22'h0);
    wire logic        out1_d    = base1 || holding;

    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            out1_q     <= 1'b0;
            out2_q     <= 1'b0;
            cmd_seen_q <= 1'b0;
            hold_cnt_q <= '0;
        end else if (tick) begin
            out1_q     <= out1_d;
            out2_q     <= near2;
            cmd_seen_q <= 1'b0;
            if (base1)
                hold_cnt_q <= hold_load;
            else if (holding)
                hold_cnt_q <= hold_cnt_q - 22'h1;
            else
                hold_cnt_q <= 22'h0;
        end else if (cmd_ok) begin
            cmd_seen_q <= 1'b1;
        end
    end

    // ==========================================
    // Inhibit input reading
    // One sample per control cycle; setting s needs 2s+1 agreeing samples, 9 for any setting above 4
    wire logic [2:0] read_set  = (cfg_q.inhibit_read > 3'h4) ? 3'h4 : cfg_q.inhibit_read;
    wire logic [3:0] need_m1   = {read_set, 1'b0};
    wire logic       smp_same  = (PULSE_INHIBIT_IN == smp_last_q);
    wire logic [3:0] agree_d   = !smp_same ? 4'h0 : ((agree_q == 4'hf) ? agree_q : agree_q + 4'h1);
    wire logic       inh_upd   = tick && (agree_d >= need_m1);

    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            smp_last_q      <= 1'b0;
            agree_q         <= '0;
            inhibit_state_q <= 1'b0;
        end else if (tick) begin
            smp_last_q <= PULSE_INHIBIT_IN;
            agree_q    <= agree_d;
            if (inh_upd)
                inhibit_state_q <= PULSE_INHIBIT_IN;
        end
    end

    // ==========================================
    // Analog speed command
    wire logic signed [17:0] ain_ofs  = 18'($signed(ANALOG_INPUT_FIRST)) + 18'(offset_q);
    wire logic signed [17:0] ain_pol  = cfg_q.polarity ? -ain_ofs : ain_ofs;
    wire logic signed [26:0] filt_x   = 27'($signed({ain_pol, 8'h0}));
    wire logic signed [26:0] filt_dif = filt_x - 27'(filt_y_q);
    wire logic signed [26:0] filt_den = $signed({14'h0, filt_q}) + 27'sh1;
    wire logic signed [26:0] filt_stp = filt_dif / filt_den;
    wire logic signed [25:0] filt_y_d = 26'(27'(filt_y_q) + filt_stp);
    // Full scale of 10 V at 2000 rpm/V stays well inside 48 bits
    wire logic signed [47:0] ana_prod = 48'($signed(filt_y_q[25:8])) * 48'($signed({1'b0, gain_q}))
                                        * 48'(ADC_LSB_UV);
    wire logic signed [31:0] ana_rpm  = 32'(ana_prod / 48'(UV_PER_V));

    // ==========================================
    // Speed source and direction
    wire logic [2:0]         sel_idx    = (cfg_q.spd_src == SRC_PRESET4) ?
                                          {1'b0, PRESET_SPEED_SEL[1:0]} : PRESET_SPEED_SEL;
    wire logic signed [31:0] preset_ext = 32'(preset_q[sel_idx]);
    wire logic               use_ana    = (cfg_q.spd_src == SRC_ANALOG) ||
                                          ((cfg_q.spd_src == SRC_MIXED) && (PRESET_SPEED_SEL == 3'h7));
    wire logic signed [31:0] raw_spd    = use_ana ? ana_rpm : preset_ext;
    wire logic [31:0]        spd_mag    = mag32(raw_spd);
    wire logic signed [31:0] spd_d      = !cfg_q.dir_sel ? raw_spd :
                                          (SPEED_SIGN_IN ? -$signed(spd_mag) : $signed(spd_mag));

    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            filt_y_q <= '0;
            spd_q    <= '0;
        end else if (tick) begin
            filt_y_q <= filt_y_d;
            spd_q    <= spd_d;
        end
    end

    // ==========================================
    // Interrupt status, a new event wins over a same-cycle clear
    wire logic [ST_W-1:0] ev;
    assign ev[ST_CLEAR]   = clr_hit;
    assign ev[ST_POS1]    = tick && out1_d && !out1_q;
    assign ev[ST_POS2]    = tick && near2 && !out2_q;
    assign ev[ST_INHIBIT] = inh_upd && (PULSE_INHIBIT_IN != inhibit_state_q);
    wire logic [ST_W-1:0] w1c = wr_status ? WDATA[ST_W-1:0] : '0;

    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN)
            status_q <= '0;
        else
            status_q <= (status_q & ~w1c) | ev;
    end

    // ==========================================
    // Outputs
    assign RDATA                  = rdata_q;
    assign IRQ                    = |(status_q & mask_q);
    assign IN_POSITION_OUT_FIRST  = out1_q;
    assign IN_POSITION_OUT_SECOND = out2_q;
    assign INHIBIT_ACTIVE         = inhibit_act;
    assign DEVIATION_COUNT        = dev_q;
    assign SPEED_CMD              = spd_q;

    // ==========================================
    // Assertions
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RSTN);

    property p_dev_clear;
        clr_hit |=> (dev_q == 32'sh0);
    endproperty
    a_dev_clear: assert property (p_dev_clear) else $error("deviation not cleared");

    property p_clear_off;
        (cfg_q.clear_mode == CLR_OFF) && DEVIATION_CLEAR_IN && !CMD_PULSE && !FB_PULSE
            |=> (dev_q == $past(dev_q));
    endproperty
    a_clear_off: assert property (p_clear_off) else $error("clear acted while off");

    property p_in_pos_first;
        tick && near1 && (cfg_q.in_pos_cond == 2'h0) |=> IN_POSITION_OUT_FIRST;
    endproperty
    a_in_pos_first: assert property (p_in_pos_first) else $error("first in-position missing");

    property p_no_cmd;
        tick && (cfg_q.in_pos_cond == 2'h1) && cmd_ok |=> !IN_POSITION_OUT_FIRST;
    endproperty
    a_no_cmd: assert property (p_no_cmd) else $error("in-position with command present");

    property p_hold;
        tick && use_hold && (hold_cnt_q > 22'h1) |=> IN_POSITION_OUT_FIRST [*2];
    endproperty
    a_hold: assert property (p_hold) else $error("in-position dropped during hold");

    property p_second;
        tick |=> (IN_POSITION_OUT_SECOND == $past(mag32(dev_d) <= {13'h0, range2_q}));
    endproperty
    a_second: assert property (p_second) else $error("second in-position wrong");

    property p_inhibit;
        INHIBIT_ACTIVE && CMD_PULSE && !FB_PULSE && !clr_hit |=> $stable(DEVIATION_COUNT);
    endproperty
    a_inhibit: assert property (p_inhibit) else $error("inhibited pulse counted");

    property p_inhibit_off;
        !cfg_q.inhibit_en |-> !INHIBIT_ACTIVE;
    endproperty
    a_inhibit_off: assert property (p_inhibit_off) else $error("inhibit active while disabled");

    property p_read_period;
        !tick |=> $stable(inhibit_state_q);
    endproperty
    a_read_period: assert property (p_read_period) else $error("inhibit moved off tick");

    property p_analog;
        tick && (cfg_q.spd_src == SRC_ANALOG) && !cfg_q.dir_sel |=> (SPEED_CMD == $past(ana_rpm));
    endproperty
    a_analog: assert property (p_analog) else $error("analog speed mismatch");

    property p_preset;
        tick && (cfg_q.spd_src == SRC_PRESET8) && !cfg_q.dir_sel |=> (SPEED_CMD == $past(preset_ext));
    endproperty
    a_preset: assert property (p_preset) else $error("preset speed mismatch");

    property p_dir;
        tick && cfg_q.dir_sel && SPEED_SIGN_IN |=> (SPEED_CMD[31] || (SPEED_CMD == 32'h0));
    endproperty
    a_dir: assert property (p_dir) else $error("direction sign ignored");

    c_clear: cover property (POS_MODE && clr_hit && (dev_q != 32'sh0));
    c_in_pos: cover property ($rose(IN_POSITION_OUT_FIRST));
    c_inhibit: cover property (INHIBIT_ACTIVE && CMD_PULSE);
    c_preset: cover property (tick && !use_ana && (preset_ext != 32'sh0));

endmodule

// ==== src/spv_pkg.sv ====
// Constants and types of the servo position/velocity command block
// What this block does
// - A deviation clear in position control forces the deviation counter to zero.
// - Clear mode 0 to 4 picks level, rising, falling, both edges or off.
// - First in-position output is on while deviation magnitude is within range one.
// - Condition 0 to 3 picks the in-position test; some also need no command.
// - Hold conditions keep in-position on for 0 to 30000 ms after it drops.
// - Second in-position output compares deviation magnitude against its own range two.
// - With inhibit enabled and active, command pulses are ignored and not counted.
// - Inhibit is disabled after reset; one setting enables it.
// - Inhibit input updates only after all samples in the reading period agree.
// - Analog command converts to speed with gain 10 to 2000 rpm per volt.
// - Polarity setting can invert the analog voltage before conversion.
// - Signed offset of -5578 to 5578 steps of 0.359 mV adds to analog input.
// - Analog input passes a first-order lag, time constant 0 to 6400 x 0.01 ms.
// - Speed source 0 to 3 selects analog or presets; analog after reset.
// - Three select inputs pick one of eight presets of -20000 to 20000 rpm.
// - Direction setting takes sign from the value or from the sign input.
package spv_pkg;

    // ==========================================
    // Timing
    localparam int CLK_PERIOD_NS  = 10;
    localparam int CTRL_PERIOD_NS = 10000;
    localparam int CTRL_CYC_DEF   = CTRL_PERIOD_NS / CLK_PERIOD_NS;
    localparam int MS_NS          = 1000000;
    localparam int MS_TICKS       = MS_NS / CTRL_PERIOD_NS;
    localparam int ADC_LSB_UV     = 359;
    localparam int UV_PER_V       = 1000000;

    // ==========================================
    // Register map
    localparam logic [7:0] REG_CTRL    = 8'h00;
    localparam logic [7:0] REG_RANGE1  = 8'h04;
    localparam logic [7:0] REG_RANGE2  = 8'h08;
    localparam logic [7:0] REG_HOLD    = 8'h0c;
    localparam logic [7:0] REG_GAIN    = 8'h10;
    localparam logic [7:0] REG_OFFSET  = 8'h14;
    localparam logic [7:0] REG_FILTER  = 8'h18;
    localparam logic [7:0] REG_STATUS  = 8'h1c;
    localparam logic [7:0] REG_MASK    = 8'h20;
    localparam logic [7:0] REG_DEV     = 8'h24;
    localparam logic [7:0] REG_SPEED   = 8'h28;
    localparam logic [7:0] REG_LIVE    = 8'h2c;
    localparam logic [7:0] REG_PRESET0 = 8'h40;

    // ==========================================
    // Reset values
    localparam logic [18:0] RANGE1_RST = 19'h0000a;
    localparam logic [18:0] RANGE2_RST = 19'h0000a;
    localparam logic [14:0] HOLD_RST   = 15'h0000;
    localparam logic [10:0] GAIN_RST   = 11'h1f4;
    localparam logic [13:0] OFFSET_RST = 14'h0000;
    localparam logic [12:0] FILTER_RST = 13'h0000;

    // ==========================================
    // Status bits
    localparam int ST_CLEAR   = 0;
    localparam int ST_POS1    = 1;
    localparam int ST_POS2    = 2;
    localparam int ST_INHIBIT = 3;
    localparam int ST_W       = 4;

    // ==========================================
    // Mode codes
    localparam logic [2:0] CLR_LEVEL = 3'h0;
    localparam logic [2:0] CLR_RISE  = 3'h1;
    localparam logic [2:0] CLR_FALL  = 3'h2;
    localparam logic [2:0] CLR_BOTH  = 3'h3;
    localparam logic [2:0] CLR_OFF   = 3'h4;
    localparam logic [1:0] SRC_ANALOG  = 2'h0;
    localparam logic [1:0] SRC_PRESET4 = 2'h1;
    localparam logic [1:0] SRC_PRESET8 = 2'h2;
    localparam logic [1:0] SRC_MIXED   = 2'h3;

    // Control register, all fields zero after reset
    typedef struct packed {
        logic [18:0] rsv;
        logic        polarity;
        logic        dir_sel;
        logic [1:0]  spd_src;
        logic [2:0]  inhibit_read;
        logic        inhibit_en;
        logic [1:0]  in_pos_cond;
        logic [2:0]  clear_mode;
    } spv_cfg_t;

endpackage
